// ===== common/jcs_pkg.sv
// package: register map, codes and states of the comm status block
package jcs_pkg;
    // register word addresses (byte offsets, one aligned word each)
    localparam logic [7:0]  ADDR_CTRL   = 8'h00;
    localparam logic [7:0]  ADDR_STATUS = 8'h04;
    localparam logic [7:0]  ADDR_CODE   = 8'h08;
    localparam logic [7:0]  ADDR_OWN    = 8'h0c;
    // control and status field positions
    localparam int          BIT_PERMIT    = 0;
    localparam int          BIT_ONLINE    = 0;
    localparam int          BIT_CONFIRMED = 1;
    localparam int          BIT_ERROR     = 2;
    localparam int          BIT_BUS_OFF   = 3;
    // station address limits
    localparam logic [7:0]  ADDR_MAX_OK   = 8'hfd;
    localparam logic [7:0]  ADDR_NULL     = 8'hfe;
    // error code values
    localparam int          CODE_W        = 16;
    localparam logic [15:0] CODE_NONE     = 16'h0000;
    localparam logic [15:0] CODE_NULL     = 16'h03e8;
    localparam logic [15:0] CODE_BUS_OFF  = 16'h0bb8;
    // error event inputs, one bit each, lowest index least severe
    localparam int          NUM_EVT       = 16;
    localparam logic [15:0] EVT_CODE [NUM_EVT] = '{
        16'h0064, 16'h0065, 16'h0066, 16'h0067,  // bam rts cts eom
        16'h0068, 16'h0069, 16'h006a, 16'h006b,  // abort dt len abort_tx
        16'h006e, 16'h00c8, 16'h00c9, 16'h07d0,  // nack txq rxq init
        16'h07d1, 16'h07d2, 16'h07d3, 16'h07d4   // reset passive active ovr
    };
    // error counter default bus-off threshold
    localparam int          ERR_CNT_W     = 9;
    localparam int          BUS_OFF_LIMIT = 256;
    localparam logic [8:0]  TX_ERR_STEP   = 9'h008;
    localparam logic [8:0]  RX_ERR_STEP   = 9'h001;
    localparam logic [8:0]  OK_STEP       = 9'h001;
    localparam logic [8:0]  CNT_ZERO      = 9'h000;

    typedef enum logic [1:0] {
        JCS_OFFLINE     = 2'b00,
        JCS_CLAIM       = 2'b01,
        JCS_CONFIRMED   = 2'b10,
        JCS_UNCONFIRMED = 2'b11
    } jcs_state_t;
endpackage

// ===== logic/jcs_comm_status.sv
// comm permit, online, address, bus-off and error code logic of a j1939 port
//
// How it works
// - software permit flag, clear after reset; clear forbids communication
// - read-only online flag; no messages pass while it is clear
// - confirmed flag sets once own address settles within 0 to 253
// - confirmed flag clears at communication start and on conflict to 254
// - no user message exchange while the address is unconfirmed
// - error flag is high exactly when the error code is non-zero
// - transmit and receive error counters reaching threshold cause bus-off
// - bus-off halts communication, goes offline and sets the bus-off flag
// - setting the permit flag clears the bus-off flag
// - error code is writable; written zero stays until a new error
// - unexpected bam, rts, cts, eom, abort, dt frames record 100 to 105
// - bad length 106, abort send failure 107, nack failure 110
// - transmit queue overflow 200, receive queue overflow 201
// - own address left at null records 1000
// - controller init failure 2000, controller reset failure 2001
// - error-passive 2002, error-active 2003, data overrun 2004
// - bus-off on the bus records 3000
// - offline straight after start of operation
// - permit set goes online and runs the address claim sequence
// - claim ending at address 254 stays unconfirmed
// - permit cleared stops processing and goes offline
module jcs_comm_status #(
    parameter int BUS_OFF_LIMIT = jcs_pkg::BUS_OFF_LIMIT
) (
    input  wire logic        clock,
    input  wire logic        arst_n,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    input  wire logic [15:0] error_event,
    input  wire logic        tx_error,
    input  wire logic        rx_error,
    input  wire logic        tx_success,
    input  wire logic        rx_success,
    input  wire logic        claim_done,
    input  wire logic [7:0]  claim_addr,
    input  wire logic        conflict_evt,
    input  wire logic [7:0]  conflict_addr,
    output logic             claim_start,
    output logic             link_online,
    output logic             msg_enable,
    output logic [7:0]       own_addr
);
    localparam logic [8:0] LIMIT = 9'(BUS_OFF_LIMIT);

    jcs_pkg::jcs_state_t state_reg;
    jcs_pkg::jcs_state_t state_next;
    logic        comm_permit_flag_reg;
    logic        permit_prev_reg;
    logic        own_address_confirmed_flag_reg;
    logic        link_error_flag_reg;
    logic        bus_off_flag_reg;
    logic [15:0] link_error_code_reg;
    logic [15:0] code_next;
    logic [8:0]  tx_cnt_reg;
    logic [8:0]  rx_cnt_reg;
    logic [7:0]  own_addr_reg;
    logic        permit_rise;
    logic        is_online;
    logic        bus_off_hit;
    logic        null_hit;
    logic        evt_any;
    logic [15:0] evt_code;
    logic        wr_ctrl;
    logic        wr_code;

    assign wr_ctrl     = reg_wr && (reg_addr == jcs_pkg::ADDR_CTRL);
    assign wr_code     = reg_wr && (reg_addr == jcs_pkg::ADDR_CODE);
    assign permit_rise = comm_permit_flag_reg && !permit_prev_reg;
    assign is_online   = (state_reg != jcs_pkg::JCS_OFFLINE);

    // counters only count while attached, so threshold means bus-off
    assign bus_off_hit = is_online && ((tx_cnt_reg >= LIMIT) ||
                                       (rx_cnt_reg >= LIMIT));

    // claim or conflict that leaves the station on the null address
    assign null_hit = ((state_reg == jcs_pkg::JCS_CLAIM) && claim_done &&
                       (claim_addr > jcs_pkg::ADDR_MAX_OK)) ||
                      (is_online && conflict_evt &&
                       (conflict_addr == jcs_pkg::ADDR_NULL));

    // most severe pending event wins when several arrive together
    always_comb
    begin
        evt_any  = 1'b0;
        evt_code = jcs_pkg::CODE_NONE;
        for (int i = 0; i < jcs_pkg::NUM_EVT; i++)
        begin
            if (error_event[i])
            begin
                evt_any  = 1'b1;
                evt_code = jcs_pkg::EVT_CODE[i];
            end
        end
    end

    // address claim and online state walk
    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            jcs_pkg::JCS_OFFLINE:
                if (permit_rise)
                    state_next = jcs_pkg::JCS_CLAIM;
            jcs_pkg::JCS_CLAIM:
                if (claim_done)
                    state_next = (claim_addr <= jcs_pkg::ADDR_MAX_OK) ?
                                 jcs_pkg::JCS_CONFIRMED :
                                 jcs_pkg::JCS_UNCONFIRMED;
            jcs_pkg::JCS_CONFIRMED:
                if (conflict_evt && conflict_addr == jcs_pkg::ADDR_NULL)
                    state_next = jcs_pkg::JCS_UNCONFIRMED;
            jcs_pkg::JCS_UNCONFIRMED:
                if (claim_done && claim_addr <= jcs_pkg::ADDR_MAX_OK)
                    state_next = jcs_pkg::JCS_CONFIRMED;
            default:
                state_next = jcs_pkg::JCS_OFFLINE;
        endcase
        // permit loss or bus-off beats every other move
        if (!comm_permit_flag_reg || bus_off_hit)
            state_next = jcs_pkg::JCS_OFFLINE;
    end

    // state starts offline out of reset
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
            state_reg <= jcs_pkg::JCS_OFFLINE;
        else
            state_reg <= state_next;
    end

    // status outputs follow the next state so they leave from flops
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            link_online                    <= 1'b0;
            own_address_confirmed_flag_reg <= 1'b0;
            msg_enable                     <= 1'b0;
            claim_start                    <= 1'b0;
        end
        else
        begin
            link_online <= (state_next != jcs_pkg::JCS_OFFLINE);
            own_address_confirmed_flag_reg <=
                (state_next == jcs_pkg::JCS_CONFIRMED);
            msg_enable  <= (state_next == jcs_pkg::JCS_CONFIRMED);
            claim_start <= (state_reg == jcs_pkg::JCS_OFFLINE) &&
                           (state_next == jcs_pkg::JCS_CLAIM);
        end
    end

    // permit: hardware drops it on bus-off, software must set it again
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            comm_permit_flag_reg <= 1'b0;
            permit_prev_reg      <= 1'b0;
        end
        else
        begin
            permit_prev_reg <= comm_permit_flag_reg;
            if (bus_off_hit)
                comm_permit_flag_reg <= 1'b0;
            else if (wr_ctrl)
                comm_permit_flag_reg <= reg_wdata[jcs_pkg::BIT_PERMIT];
        end
    end

    // bus-off flag: set wins over the clear caused by a permit write
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
            bus_off_flag_reg <= 1'b0;
        else if (bus_off_hit)
            bus_off_flag_reg <= 1'b1;
        else if (wr_ctrl && reg_wdata[jcs_pkg::BIT_PERMIT])
            bus_off_flag_reg <= 1'b0;
    end

    // error counters restart from zero each time the port goes offline
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            tx_cnt_reg <= jcs_pkg::CNT_ZERO;
            rx_cnt_reg <= jcs_pkg::CNT_ZERO;
        end
        else if (!is_online)
        begin
            tx_cnt_reg <= jcs_pkg::CNT_ZERO;
            rx_cnt_reg <= jcs_pkg::CNT_ZERO;
        end
        else
        begin
            if (tx_error && tx_cnt_reg < LIMIT)
                tx_cnt_reg <= tx_cnt_reg + jcs_pkg::TX_ERR_STEP;
            else if (tx_success && tx_cnt_reg != jcs_pkg::CNT_ZERO)
                tx_cnt_reg <= tx_cnt_reg - jcs_pkg::OK_STEP;
            if (rx_error && rx_cnt_reg < LIMIT)
                rx_cnt_reg <= rx_cnt_reg + jcs_pkg::RX_ERR_STEP;
            else if (rx_success && rx_cnt_reg != jcs_pkg::CNT_ZERO)
                rx_cnt_reg <= rx_cnt_reg - jcs_pkg::OK_STEP;
        end
    end

    // own station address, null until a claim settles it
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
            own_addr_reg <= jcs_pkg::ADDR_NULL;
        else if (state_reg == jcs_pkg::JCS_OFFLINE && permit_rise)
            own_addr_reg <= jcs_pkg::ADDR_NULL;
        else if (is_online && claim_done)
            own_addr_reg <= claim_addr;
        else if (is_online && conflict_evt)
            own_addr_reg <= conflict_addr;
    end
    assign own_addr = own_addr_reg;

    // newest error overwrites; an event beats a software write
    always_comb
    begin
        code_next = link_error_code_reg;
        if (bus_off_hit)
            code_next = jcs_pkg::CODE_BUS_OFF;
        else if (null_hit)
            code_next = jcs_pkg::CODE_NULL;
        else if (evt_any)
            code_next = evt_code;
        else if (wr_code)
            code_next = reg_wdata[jcs_pkg::CODE_W-1:0];
    end

    // code and its flag move together so they never disagree
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            link_error_code_reg <= jcs_pkg::CODE_NONE;
            link_error_flag_reg <= 1'b0;
        end
        else
        begin
            link_error_code_reg <= code_next;
            link_error_flag_reg <= (code_next != jcs_pkg::CODE_NONE);
        end
    end

    // read port: data in the cycle after the strobe, unmapped reads zero
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
            reg_rdata <= 32'h0000_0000;
        else if (!reg_rd)
            reg_rdata <= 32'h0000_0000;
        else
        begin
            reg_rdata <= 32'h0000_0000;
            case (reg_addr)
                jcs_pkg::ADDR_CTRL:
                    reg_rdata[jcs_pkg::BIT_PERMIT] <= comm_permit_flag_reg;
                jcs_pkg::ADDR_STATUS:
                begin
                    reg_rdata[jcs_pkg::BIT_ONLINE]    <= link_online;
                    reg_rdata[jcs_pkg::BIT_CONFIRMED] <=
                        own_address_confirmed_flag_reg;
                    reg_rdata[jcs_pkg::BIT_ERROR]     <= link_error_flag_reg;
                    reg_rdata[jcs_pkg::BIT_BUS_OFF]   <= bus_off_flag_reg;
                end
                jcs_pkg::ADDR_CODE:
                    reg_rdata[jcs_pkg::CODE_W-1:0] <= link_error_code_reg;
                jcs_pkg::ADDR_OWN:
                    reg_rdata[7:0] <= own_addr_reg;
                default:
                    reg_rdata <= 32'h0000_0000;
            endcase
        end
    end

    // checks on the block's outputs and internal status registers
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!arst_n);

    sequence s_claim_ok;
        state_reg == jcs_pkg::JCS_CLAIM && claim_done &&
        claim_addr <= jcs_pkg::ADDR_MAX_OK && comm_permit_flag_reg &&
        !bus_off_hit;
    endsequence

    sequence s_claim_null;
        state_reg == jcs_pkg::JCS_CLAIM && claim_done &&
        claim_addr == jcs_pkg::ADDR_NULL && comm_permit_flag_reg &&
        !bus_off_hit;
    endsequence

    property p_permit_off;
        !comm_permit_flag_reg |=> !link_online && !msg_enable;
    endproperty
    a_permit_off: assert property (p_permit_off)
        else $error("online while permit clear");

    property p_go_online;
        permit_rise && state_reg == jcs_pkg::JCS_OFFLINE && !bus_off_hit
        |=> link_online && claim_start && !own_address_confirmed_flag_reg
            ##1 !claim_start;
    endproperty
    a_go_online: assert property (p_go_online)
        else $error("permit set did not start claim");

    property p_confirm;
        s_claim_ok |=> own_address_confirmed_flag_reg && msg_enable;
    endproperty
    a_confirm: assert property (p_confirm)
        else $error("settled address not confirmed");

    property p_null_claim;
        s_claim_null |=> !own_address_confirmed_flag_reg &&
                         link_error_code_reg == jcs_pkg::CODE_NULL;
    endproperty
    a_null_claim: assert property (p_null_claim)
        else $error("null claim not reported");

    property p_no_msg_unconf;
        !own_address_confirmed_flag_reg |-> !msg_enable;
    endproperty
    a_no_msg_unconf: assert property (p_no_msg_unconf)
        else $error("messages enabled while unconfirmed");

    property p_err_flag;
        ##1 link_error_flag_reg == (link_error_code_reg != 16'h0000);
    endproperty
    a_err_flag: assert property (p_err_flag)
        else $error("error flag disagrees with code");

    property p_bus_off;
        bus_off_hit |=> bus_off_flag_reg && !link_online &&
                        !comm_permit_flag_reg &&
                        link_error_code_reg == jcs_pkg::CODE_BUS_OFF;
    endproperty
    a_bus_off: assert property (p_bus_off)
        else $error("bus-off not handled");

    property p_bus_off_clear;
        wr_ctrl && reg_wdata[jcs_pkg::BIT_PERMIT] && !bus_off_hit
        |=> !bus_off_flag_reg;
    endproperty
    a_bus_off_clear: assert property (p_bus_off_clear)
        else $error("bus-off flag not cleared by permit");

    property p_code_zero;
        wr_code && reg_wdata[15:0] == 16'h0000 && !bus_off_hit &&
        !null_hit && !evt_any
        |=> link_error_code_reg == 16'h0000 && !link_error_flag_reg;
    endproperty
    a_code_zero: assert property (p_code_zero)
        else $error("written zero not kept");

    property p_mp_first;
        error_event == 16'h0001 && !bus_off_hit && !null_hit
        |=> link_error_code_reg == 16'h0064;
    endproperty
    a_mp_first: assert property (p_mp_first)
        else $error("bam error code wrong");

    property p_busoff_msg;
        bus_off_flag_reg |-> !msg_enable;
    endproperty
    a_busoff_msg: assert property (p_busoff_msg)
        else $error("messages enabled during bus-off");
endmodule

// ===== test/jcs_far_end.sv
// far-end model: other controller applications answering the address claim
module jcs_far_end (
    input  wire logic       clock,
    input  wire logic       arst_n,
    input  wire logic       claim_start,
    input  wire logic       link_online,
    input  wire logic [7:0] cfg_addr,
    input  wire logic [7:0] cfg_delay,
    input  wire logic       conflict_req,
    output logic            claim_done,
    output logic [7:0]      claim_addr,
    output logic            conflict_evt,
    output logic [7:0]      conflict_addr
);
    timeunit 1ns;
    timeprecision 1ps;

    logic       busy_reg;
    logic [7:0] wait_reg;
    logic [7:0] addr_reg;

    // claim settles after a quiet time; dropped when the link goes down
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            busy_reg   <= 1'b0;
            wait_reg   <= 8'h00;
            claim_done <= 1'b0;
        end
        else
        begin
            claim_done <= 1'b0;
            if (claim_start)
            begin
                busy_reg <= 1'b1;
                wait_reg <= cfg_delay;
            end
            else if (!link_online)
                busy_reg <= 1'b0;
            else if (busy_reg && wait_reg == 8'h00)
            begin
                busy_reg   <= 1'b0;
                claim_done <= 1'b1;
            end
            else if (busy_reg)
                wait_reg <= wait_reg - 8'h01;
        end
    end

    // conflict report one cycle after the bench asks for it
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            conflict_evt <= 1'b0;
            addr_reg     <= 8'h00;
        end
        else
        begin
            conflict_evt <= conflict_req;
            addr_reg     <= cfg_addr;
        end
    end

    // address is only meaningful with its strobe; inverted otherwise so
    // that a design sampling it late cannot get lucky
    assign claim_addr    = claim_done ? addr_reg : ~addr_reg;
    assign conflict_addr = conflict_evt ? addr_reg : ~addr_reg;
endmodule

// ===== test/jcs_comm_status_test.sv
// self-checking bench of the comm status block with far-end model
module jcs_comm_status_test;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int LIM = 16;
    logic        clock, arst_n, reg_wr, reg_rd, rd_d, conflict_req;
    logic        claim_done, conflict_evt, claim_start, link_online;
    logic        msg_enable;
    logic [3:0]  cnt_pls;
    logic [7:0]  reg_addr, cfg_addr, cfg_delay, claim_addr, conflict_addr;
    logic [7:0]  own_addr, a;
    logic [15:0] error_event;
    logic [31:0] reg_wdata, reg_rdata, r;
    logic [31:0] exp_q[$];
    int          errors, n_compared, seed, i;
    logic [15:0] codes [16] = '{16'h0064, 16'h0065, 16'h0066, 16'h0067,
        16'h0068, 16'h0069, 16'h006a, 16'h006b, 16'h006e, 16'h00c8,
        16'h00c9, 16'h07d0, 16'h07d1, 16'h07d2, 16'h07d3, 16'h07d4};

    jcs_comm_status #(.BUS_OFF_LIMIT(LIM)) jcs_comm_status_inst (
        .clock(clock), .arst_n(arst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .error_event(error_event),
        .tx_error(cnt_pls[0]), .rx_error(cnt_pls[1]),
        .tx_success(cnt_pls[2]), .rx_success(cnt_pls[3]),
        .claim_done(claim_done), .claim_addr(claim_addr),
        .conflict_evt(conflict_evt), .conflict_addr(conflict_addr),
        .claim_start(claim_start), .link_online(link_online),
        .msg_enable(msg_enable), .own_addr(own_addr));

    jcs_far_end jcs_far_end_inst (
        .clock(clock), .arst_n(arst_n), .claim_start(claim_start),
        .link_online(link_online), .cfg_addr(cfg_addr),
        .cfg_delay(cfg_delay), .conflict_req(conflict_req),
        .claim_done(claim_done), .claim_addr(claim_addr),
        .conflict_evt(conflict_evt), .conflict_addr(conflict_addr));

    // status word: bus-off, error, confirmed, online from bit 3 down
    function automatic logic [31:0] st(input logic on, cf, er, bo);
        return {28'h0000000, bo, er, cf, on};
    endfunction

    task chk(input logic [31:0] got, input logic [31:0] exp,
             input string m);
        n_compared++;
        if (got !== exp)
        begin
            errors++;
            $display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask

    task wr(input logic [7:0] ad, input logic [31:0] d);
        @(posedge clock);
        reg_addr  <= ad;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clock);
        reg_wr    <= 1'b0;
    endtask

    // the expected word is noted now; the monitor compares it later
    task rd(input logic [7:0] ad, input logic [31:0] e);
        @(posedge clock);
        reg_addr <= ad;
        reg_rd   <= 1'b1;
        exp_q.push_back(e);
        @(posedge clock);
        reg_rd   <= 1'b0;
    endtask

    task pulse(input logic [15:0] ev, input logic [3:0] cp);
        @(posedge clock);
        error_event <= ev;
        cnt_pls     <= cp;
        @(posedge clock);
        error_event <= 16'h0000;
        cnt_pls     <= 4'h0;
    endtask

    // bounded wait on claim_start (sel 0) or claim_done (sel 1)
    task wait_on(input logic sel);
        int k;
        for (k = 0; k < 60; k++)
        begin
            @(negedge clock);
            if ((sel ? claim_done : claim_start) === 1'b1)
                break;
        end
        chk({31'h0, k < 60}, 32'h1, "handshake never came");
    endtask

    // permit set, claim runs, far end settles on address ad
    task go_online(input logic [7:0] ad, input logic e);
        r = $random(seed);
        cfg_addr  <= ad;
        cfg_delay <= 8'h08 + {5'h00, r[2:0]};
        wr(jcs_pkg::ADDR_CTRL, 32'h1);
        wait_on(1'b0);
        chk({31'h0, link_online}, 32'h1, "not online");
        rd(jcs_pkg::ADDR_STATUS, st(1, 0, e, 0));
        wait_on(1'b1);
    endtask

    task test_done;
        $display("errors %0d compared %0d", errors, n_compared);
        if (errors == 0 && n_compared > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    initial
    begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    // read data stands only in the cycle after the strobe
    always @(posedge clock)
        rd_d <= reg_rd;
    always @(negedge clock)
        if (rd_d === 1'b1)
            chk(reg_rdata, exp_q.pop_front(), "read data");

    initial
    begin
        #100us;
        errors++;
        test_done;
    end

    initial
    begin
        // rd_d is left to the monitor, its only driver
        arst_n = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 32'h0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        error_event = 16'h0;
        cnt_pls = 4'h0;
        cfg_addr = 8'h00;
        cfg_delay = 8'h08;
        conflict_req = 1'b0;
        errors = 0;
        n_compared = 0;
        seed = 87;
        repeat (16) @(posedge clock);
        arst_n <= 1'b1;
        // reset values, unmapped place, read-only status write
        wr(jcs_pkg::ADDR_STATUS, 32'hf);
        rd(jcs_pkg::ADDR_CTRL, 32'h0);
        rd(jcs_pkg::ADDR_STATUS, 32'h0);
        rd(jcs_pkg::ADDR_OWN, 32'hfe);
        rd(8'h10, 32'h0);
        // every event code, recorded while offline, latest wins
        for (i = 0; i < 16; i++)
        begin
            pulse(16'h0001 << i, 4'h0);
            r = {16'h0, codes[i]};
            rd(jcs_pkg::ADDR_CODE, r);
            rd(jcs_pkg::ADDR_STATUS, st(0, 0, 1, 0));
        end
        wr(jcs_pkg::ADDR_CODE, 32'h0);
        rd(jcs_pkg::ADDR_CODE, 32'h0);
        rd(jcs_pkg::ADDR_STATUS, 32'h0);
        r = $random(seed) | 32'h8000;
        wr(jcs_pkg::ADDR_CODE, r);
        rd(jcs_pkg::ADDR_CODE, {16'h0, r[15:0]});
        // software write and event in the same cycle: event wins
        @(posedge clock);
        reg_addr    <= jcs_pkg::ADDR_CODE;
        reg_wdata   <= 32'h0;
        reg_wr      <= 1'b1;
        error_event <= 16'h0001;
        @(posedge clock);
        reg_wr      <= 1'b0;
        error_event <= 16'h0000;
        rd(jcs_pkg::ADDR_CODE, 32'h64);
        // claim to a random legal address
        wr(jcs_pkg::ADDR_CODE, 32'h0);
        r = $random(seed);
        a = 8'(r[15:0] % 16'h00fe);
        go_online(a, 1'b0);
        rd(jcs_pkg::ADDR_STATUS, st(1, 1, 0, 0));
        rd(jcs_pkg::ADDR_OWN, {24'h0, a});
        chk({24'h0, own_addr}, {24'h0, a}, "own addr port");
        chk({31'h0, msg_enable}, 32'h1, "msg off");
        // conflict drops own address to null
        cfg_addr     <= jcs_pkg::ADDR_NULL;
        conflict_req <= 1'b1;
        @(posedge clock);
        conflict_req <= 1'b0;
        repeat (3) @(posedge clock);
        rd(jcs_pkg::ADDR_STATUS, st(1, 0, 1, 0));
        rd(jcs_pkg::ADDR_CODE, 32'h3e8);
        chk({31'h0, msg_enable}, 32'h0, "msg on");
        chk({24'h0, own_addr}, 32'hfe, "own addr not null");
        // permit cleared, then a claim that ends at null
        wr(jcs_pkg::ADDR_CTRL, 32'h0);
        repeat (3) @(negedge clock);
        chk({31'h0, link_online}, 32'h0, "still online");
        wr(jcs_pkg::ADDR_CODE, 32'h0);
        go_online(jcs_pkg::ADDR_NULL, 1'b0);
        rd(jcs_pkg::ADDR_STATUS, st(1, 0, 1, 0));
        // bus-off: 8, 7, 15 stays below the limit, 23 crosses it
        wr(jcs_pkg::ADDR_CTRL, 32'h0);
        wr(jcs_pkg::ADDR_CODE, 32'h0);
        go_online(a, 1'b0);
        pulse(16'h0, 4'h1);
        pulse(16'h0, 4'h4);
        pulse(16'h0, 4'h1);
        pulse(16'h0, 4'ha);
        rd(jcs_pkg::ADDR_STATUS, st(1, 1, 0, 0));
        pulse(16'h0, 4'h1);
        repeat (2) @(negedge clock);
        chk({31'h0, link_online}, 32'h0, "online after bus-off");
        chk({31'h0, msg_enable}, 32'h0, "msg after bus-off");
        rd(jcs_pkg::ADDR_CTRL, 32'h0);
        rd(jcs_pkg::ADDR_STATUS, st(0, 0, 1, 1));
        rd(jcs_pkg::ADDR_CODE, 32'hbb8);
        // the controlling party sets the permit again to recover
        go_online(a, 1'b1);
        rd(jcs_pkg::ADDR_STATUS, st(1, 1, 1, 0));
        repeat (4) @(posedge clock);
        test_done;
    end
endmodule
